// ===== design/mdcr_ctrl.sv
// Functional notes
// R1 - Setting bit 31 starts a store of the working configuration into nonvolatile memory.
// R2 - Setting bit 30 starts a reload of the default configuration from nonvolatile memory.
// R3 - Writing 1 to bit 29 clears all faults and writing 1 to bit 28 zeroes the retry count.
// R4 - Bits 27-20 are a write-only key, and a store runs only when the key matches.
// R5 - Bits 19-11 hold an angle that is applied modulo 360 during forced alignment.
// R6 - In serial-bus mode the host writes 1 to bit 10 within every keepalive period.
// R7 - The device clears the keepalive bit by itself after the host sets it.
// R8 - The register sits at offset EAh and all its fields reset to zero.
// R9 - The host leaves every unlisted offset untouched.
// R10 - With forced alignment enabled and an alignment start-up, the device stays aligned.
// R11 - Bits 9 to 0 read as zero and ignore writes.
`include "mdcr_map.svh"

module mdcr_ctrl
   import mdcr_pkg::*;
(
   input  wire logic                    ref_clk,          // System clock, 20 MHz
   input  wire logic                    resetn,           // Async reset, active low
   input  wire logic                    reg_wr_en,        // Register write strobe
   input  wire logic                    reg_rd_en,        // Register read strobe
   input  wire logic [`MDCR_ADDR_W-1:0] reg_addr,         // Register offset
   input  wire logic [31:0]             reg_wdata,        // Write data
   output logic [31:0]                  reg_rdata,        // Read data
   output logic                         reg_rvalid,       // Read data valid
   input  wire logic                    nvm_done,         // Memory operation finished
   output logic                         nvm_store_req,    // Start store, one cycle
   output logic                         nvm_load_req,     // Start reload, one cycle
   output logic                         nvm_store_denied, // Store refused by key
   output logic                         fault_clear_cmd,  // Clear faults, one cycle
   output logic                         retry_counter_clear_cmd, // Zero retry count
   output logic                         keepalive_seen,   // Host keepalive, one cycle
   output mdcr_angle_t                  forced_angle,     // Applied align angle
   input  wire logic                    force_align_en,   // Forced alignment enable
   input  wire logic                    startup_is_align, // Start-up uses alignment
   output logic                         align_hold        // Remain in alignment
);
   mdcr_nvm_state_t nvm_state_ff;
   mdcr_nvm_state_t nxt_nvm_state;
   mdcr_angle_t     angle_ff;
   mdcr_angle_t     nxt_angle;
   logic            keepalive_ff;
   logic            nxt_keepalive;
   logic            store_req_ff;
   logic            nxt_store_req;
   logic            load_req_ff;
   logic            nxt_load_req;
   logic            denied_ff;
   logic            nxt_denied;
   logic            flt_clr_ff;
   logic            nxt_flt_clr;
   logic            retry_clr_ff;
   logic            nxt_retry_clr;
   logic            align_hold_ff;
   logic            nxt_align_hold;
   logic [31:0]     rdata_ff;
   logic [31:0]     nxt_rdata;
   logic            rvalid_ff;
   logic            nxt_rvalid;
   logic            ctrl_wr;
   logic            key_ok;
   logic [31:0]     ctrl_view;

   assign ctrl_wr = reg_wr_en && (reg_addr == `MDCR_CTRL_OFFSET); // see R8
   assign key_ok  = (reg_wdata[`MDCR_KEY_MSB:`MDCR_KEY_LSB] == `MDCR_NVM_KEY);

   // Memory command sequencer; new commands are ignored while one is running
   always_comb begin
      nxt_nvm_state = nvm_state_ff;
      nxt_store_req = 1'b0;
      nxt_load_req  = 1'b0;
      nxt_denied    = 1'b0;
      unique case (nvm_state_ff)
         MDCR_NVM_IDLE: begin
            if (ctrl_wr && reg_wdata[`MDCR_STORE_BIT]) begin
               if (key_ok) begin
                  nxt_nvm_state = MDCR_NVM_STORE; // see R1
                  nxt_store_req = 1'b1;           // see R4
               end else begin
                  nxt_denied = 1'b1;              // see R4
               end
            end else if (ctrl_wr && reg_wdata[`MDCR_LOAD_BIT]) begin
               nxt_nvm_state = MDCR_NVM_LOAD;     // see R2
               nxt_load_req  = 1'b1;
            end
         end
         MDCR_NVM_STORE,
         MDCR_NVM_LOAD: begin
            if (nvm_done) begin
               nxt_nvm_state = MDCR_NVM_IDLE;
            end
         end
         default: begin
            nxt_nvm_state = MDCR_NVM_IDLE;
         end
      endcase
   end

   always_comb begin
      nxt_flt_clr   = ctrl_wr && reg_wdata[`MDCR_FLT_CLR_BIT];   // see R3
      nxt_retry_clr = ctrl_wr && reg_wdata[`MDCR_RETRY_CLR_BIT]; // see R3
      nxt_angle     = angle_ff;
      if (ctrl_wr) begin
         nxt_angle = reg_wdata[`MDCR_ANGLE_MSB:`MDCR_ANGLE_LSB]; // see R5
      end
      // A new host write wins over the self-clear
      nxt_keepalive  = ctrl_wr && reg_wdata[`MDCR_KEEPALIVE_BIT]; // see R7
      nxt_align_hold = force_align_en && startup_is_align;        // see R10
   end

   // Write-only fields and reserved bits read as zero
   always_comb begin
      ctrl_view                      = `MDCR_CTRL_RESET; // see R11
      ctrl_view[`MDCR_STORE_BIT]     = (nvm_state_ff == MDCR_NVM_STORE);
      ctrl_view[`MDCR_LOAD_BIT]      = (nvm_state_ff == MDCR_NVM_LOAD);
      ctrl_view[`MDCR_KEEPALIVE_BIT] = keepalive_ff;
      nxt_rvalid = reg_rd_en;
      nxt_rdata  = rdata_ff;
      if (reg_rd_en) begin
         nxt_rdata = (reg_addr == `MDCR_CTRL_OFFSET) ? ctrl_view : `MDCR_CTRL_RESET;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         nvm_state_ff  <= MDCR_NVM_IDLE;
         angle_ff      <= `MDCR_ANGLE_RESET;
         keepalive_ff  <= 1'b0;
         store_req_ff  <= 1'b0;
         load_req_ff   <= 1'b0;
         denied_ff     <= 1'b0;
         flt_clr_ff    <= 1'b0;
         retry_clr_ff  <= 1'b0;
         align_hold_ff <= 1'b0;
         rdata_ff      <= `MDCR_CTRL_RESET;
         rvalid_ff     <= 1'b0;
      end else begin
         nvm_state_ff  <= nxt_nvm_state;
         angle_ff      <= nxt_angle;
         keepalive_ff  <= nxt_keepalive;
         store_req_ff  <= nxt_store_req;
         load_req_ff   <= nxt_load_req;
         denied_ff     <= nxt_denied;
         flt_clr_ff    <= nxt_flt_clr;
         retry_clr_ff  <= nxt_retry_clr;
         align_hold_ff <= nxt_align_hold;
         rdata_ff      <= nxt_rdata;
         rvalid_ff     <= nxt_rvalid;
      end
   end

   mdcr_angle_mod u_angle_mod (
      .ref_clk   (ref_clk),
      .resetn    (resetn),
      .angle_raw (angle_ff),
      .angle_mod (forced_angle)
   );

   assign reg_rdata               = rdata_ff;
   assign reg_rvalid              = rvalid_ff;
   assign nvm_store_req           = store_req_ff;
   assign nvm_load_req            = load_req_ff;
   assign nvm_store_denied        = denied_ff;
   assign fault_clear_cmd         = flt_clr_ff;
   assign retry_counter_clear_cmd = retry_clr_ff;
   assign keepalive_seen          = keepalive_ff; // see R6
   assign align_hold              = align_hold_ff;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   sequence s_store_write;
      ctrl_wr && reg_wdata[`MDCR_STORE_BIT] && key_ok && (nvm_state_ff == MDCR_NVM_IDLE);
   endsequence

   sequence s_store_running;
      nvm_store_req && (nvm_state_ff == MDCR_NVM_STORE);
   endsequence

   a_store_starts: assert property (s_store_write |=> s_store_running) // see R1
      else $error("store command did not start a store");

   a_store_key_gate: assert property (nvm_store_req |-> $past(key_ok) && $past(ctrl_wr)) // see R4
      else $error("store issued without a matching key");

   a_load_starts: assert property (
      ctrl_wr && reg_wdata[`MDCR_LOAD_BIT] && !reg_wdata[`MDCR_STORE_BIT]
      && (nvm_state_ff == MDCR_NVM_IDLE) |=> nvm_load_req ##1 !nvm_load_req) // see R2
      else $error("load command did not give one load request");

   a_fault_clear: assert property (
      fault_clear_cmd == $past(ctrl_wr && reg_wdata[`MDCR_FLT_CLR_BIT])) // see R3
      else $error("fault clear pulse does not follow the write");

   a_retry_clear: assert property (
      retry_counter_clear_cmd |=> !retry_counter_clear_cmd || $past(ctrl_wr)) // see R3
      else $error("retry clear pulse stretched without a write");

   a_angle_mod: assert property (
      ctrl_wr && !$past(reg_wr_en) |=> ##1 (forced_angle ==
      ((angle_ff >= `MDCR_ANGLE_FULL_TURN) ? angle_ff - `MDCR_ANGLE_FULL_TURN : angle_ff))) // see R5
      else $error("applied angle is not the stored angle modulo a full turn");

   a_angle_range: assert property (forced_angle < `MDCR_ANGLE_FULL_TURN) // see R5
      else $error("applied angle reaches a full turn");

   a_keepalive_clr: assert property (
      keepalive_ff && !ctrl_wr |=> !keepalive_ff) // see R7
      else $error("keepalive bit not cleared by the device");

   a_rsvd_zero: assert property (
      rvalid_ff |-> (reg_rdata[`MDCR_KEEPALIVE_BIT-1:0] == '0)
      && (reg_rdata[`MDCR_FLT_CLR_BIT:`MDCR_ANGLE_LSB] == '0)) // see R11
      else $error("reserved or write-only bits read nonzero");

   a_unmapped_zero: assert property (
      reg_rd_en && (reg_addr != `MDCR_CTRL_OFFSET)
      |=> reg_rvalid && (reg_rdata == `MDCR_CTRL_RESET)) // see R8
      else $error("unmapped offset returned data");

   a_align_hold: assert property (
      force_align_en && startup_is_align |=> align_hold) // see R10
      else $error("alignment not held while forced");
endmodule : mdcr_ctrl

// ===== design/mdcr_map.svh
`ifndef MDCR_MAP_SVH
`define MDCR_MAP_SVH

`define MDCR_ADDR_W            12
`define MDCR_CTRL_OFFSET       12'h0EA
`define MDCR_CTRL_RESET        32'h00000000
`define MDCR_STORE_BIT         31
`define MDCR_LOAD_BIT          30
`define MDCR_FLT_CLR_BIT       29
`define MDCR_RETRY_CLR_BIT     28
`define MDCR_KEY_MSB           27
`define MDCR_KEY_LSB           20
`define MDCR_ANGLE_MSB         19
`define MDCR_ANGLE_LSB         11
`define MDCR_KEEPALIVE_BIT     10
// Arbitrary unlock value that permits a store
`define MDCR_NVM_KEY           8'hA5
`define MDCR_ANGLE_FULL_TURN   9'h168
`define MDCR_ANGLE_RESET       9'h000

`endif

// ===== design/mdcr_pkg.sv
package mdcr_pkg;
   typedef enum logic [2:0] {
      MDCR_NVM_IDLE  = 3'h1,
      MDCR_NVM_STORE = 3'h2,
      MDCR_NVM_LOAD  = 3'h4
   } mdcr_nvm_state_t;

   typedef logic [8:0] mdcr_angle_t;
endpackage : mdcr_pkg

// ===== design/mdcr_angle_mod.sv
`include "mdcr_map.svh"

module mdcr_angle_mod
   import mdcr_pkg::*;
(
   input  wire logic        ref_clk,    // System clock
   input  wire logic        resetn,     // Async reset, active low
   input  wire mdcr_angle_t angle_raw,  // Stored nine-bit angle
   output mdcr_angle_t      angle_mod   // Angle reduced below a full turn
);
   mdcr_angle_t angle_mod_ff;
   mdcr_angle_t nxt_angle_mod;

   // A nine-bit value is below two full turns, so one subtraction is enough
   always_comb begin
      if (angle_raw >= `MDCR_ANGLE_FULL_TURN) begin
         nxt_angle_mod = angle_raw - `MDCR_ANGLE_FULL_TURN; // see R5
      end else begin
         nxt_angle_mod = angle_raw;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         angle_mod_ff <= `MDCR_ANGLE_RESET;
      end else begin
         angle_mod_ff <= nxt_angle_mod;
      end
   end

   assign angle_mod = angle_mod_ff;
endmodule : mdcr_angle_mod

// ===== testbench/mdcr_nvm_model.sv
module mdcr_nvm_model (
   input  wire logic       ref_clk,  // System clock
   input  wire logic       resetn,   // Async reset, active low
   input  wire logic       start,    // Store or reload request
   input  wire logic [7:0] latency,  // Cycles until done
   output logic            done      // Operation finished, one cycle
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cnt_ff;
   logic       busy_ff;
   // Finishes a store or reload after a latency the bench chooses
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_ff  <= 8'h00;
         busy_ff <= 1'b0;
         done    <= 1'b0;
      end else begin
         done <= busy_ff && (cnt_ff == 8'h00);
         if (start) begin
            busy_ff <= 1'b1;
            cnt_ff  <= latency;
         end else if (busy_ff) begin
            if (cnt_ff == 8'h00) busy_ff <= 1'b0;
            else cnt_ff <= cnt_ff - 8'h01;
         end
      end
   end
endmodule : mdcr_nvm_model

// ===== testbench/testbench.sv
module testbench
   import mdcr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [31:0] b;
      logic [8:0]  raw;
      logic [5:0]  p;
      mdcr_angle_t a;
   } mdcr_row_t;
   logic        ref_clk = 1'b0, resetn = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
   logic        force_align_en = 1'b0, startup_is_align = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic [7:0]  lat = 8'h03;
   logic        reg_rvalid, nvm_done, nvm_store_req, nvm_load_req, nvm_store_denied;
   logic        fault_clear_cmd, retry_counter_clear_cmd, keepalive_seen, align_hold;
   mdcr_angle_t forced_angle;
   int          err_count = 0, n_tests = 0, cyc = 0;
   // Pulses: store, load, denied, fault clear, retry clear, keepalive
   mdcr_row_t   rows [7] = '{
      '{32'h20000000, 9'h000, 6'h04, 9'h000},
      '{32'h10000000, 9'h167, 6'h02, 9'h167},
      '{32'h00000400, 9'h168, 6'h01, 9'h000},
      '{32'h8A500000, 9'h1FF, 6'h20, 9'h097},
      '{32'h85A00000, 9'h0B4, 6'h08, 9'h0B4},
      '{32'h40000000, 9'h169, 6'h10, 9'h001},
      '{32'h000003FF, 9'h000, 6'h00, 9'h000}};

   mdcr_ctrl mdcr_ctrl_i (.ref_clk, .resetn, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
      .reg_rdata, .reg_rvalid, .nvm_done, .nvm_store_req, .nvm_load_req, .nvm_store_denied,
      .fault_clear_cmd, .retry_counter_clear_cmd, .keepalive_seen, .forced_angle,
      .force_align_en, .startup_is_align, .align_hold);
   mdcr_nvm_model mdcr_nvm_model_i (.ref_clk, .resetn, .start(nvm_store_req | nvm_load_req),
      .latency(lat), .done(nvm_done));

   always #25 ref_clk = ~ref_clk;

   task automatic tally_and_finish;
      if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr_en = 1'b1;
      @(negedge ref_clk);
      reg_wr_en = 1'b0;
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      reg_addr  = a;
      reg_rd_en = 1'b1;
      @(negedge ref_clk);
      reg_rd_en = 1'b0;
      chk("rvalid", reg_rvalid, 32'h1);
      chk("rdata", reg_rdata, exp);
   endtask : rd

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 2000) begin
         err_count++;
         tally_and_finish();
      end
   end

   initial begin
      repeat (12) @(negedge ref_clk);
      chk("reset outputs", {forced_angle, align_hold, keepalive_seen}, 32'h0);
      resetn = 1'b1;
      rd(12'h0EA, 32'h0);
      foreach (rows[i]) begin
         wr(12'h0EA, rows[i].b | (32'(rows[i].raw) << 11));
         chk("pulses", {nvm_store_req, nvm_load_req, nvm_store_denied, fault_clear_cmd,
            retry_counter_clear_cmd, keepalive_seen}, 32'(rows[i].p));
         @(negedge ref_clk);
         chk("angle", 32'(forced_angle), 32'(rows[i].a));
         chk("keepalive", keepalive_seen, 32'h0);
         repeat (12) @(negedge ref_clk);
         rd(12'h0EA, 32'h0);
      end
      // Slow memory: busy flag, load refused while busy, store wins over load
      lat = 8'h14;
      wr(12'h0EA, 32'hCA500000);
      chk("both", {nvm_store_req, nvm_load_req}, 32'h2);
      rd(12'h0EA, 32'h80000000);
      wr(12'h0EA, 32'h40000000);
      chk("load busy", nvm_load_req, 32'h0);
      repeat (30) @(negedge ref_clk);
      rd(12'h0EA, 32'h0);
      wr(12'h0EC, 32'h20000400);
      chk("unmapped", {fault_clear_cmd, keepalive_seen}, 32'h0);
      rd(12'h0EC, 32'h0);
      for (int i = 0; i < 4; i++) begin
         {force_align_en, startup_is_align} = i[1:0];
         repeat (2) @(negedge ref_clk);
         chk("hold", align_hold, 32'(i == 3));
      end
      wr(12'h0EA, 32'h0002D000);
      @(negedge ref_clk);
      resetn = 1'b0;
      @(negedge ref_clk);
      chk("mid reset", {forced_angle, align_hold}, 32'h0);
      resetn = 1'b1;
      repeat (2) @(negedge ref_clk);
      chk("after reset", {forced_angle, align_hold}, 32'h1);
      rd(12'h0EA, 32'h0);
      tally_and_finish();
   end
endmodule : testbench
